//--- src/srl_pkg.sv
// Constants and types of the speed dependent flow ramp limiter
package srl_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int          CFG_N          = 12;
  localparam logic [10:0] FLOW_MAX       = 11'h3e8;
  localparam logic [31:0] FULL_SCALE_FX  = 32'h03e80000;
  localparam logic [15:0] TIME_MIN       = 16'h0001;
  localparam logic [15:0] TIME_MAX       = 16'h03e8;
  localparam logic [15:0] THR_OFF        = 16'h03e8;
  localparam logic [10:0] BP_LOW         = 11'h032;
  localparam logic [10:0] BP_MID         = 11'h078;
  localparam logic [10:0] BP_HIGH        = 11'h14d;
  localparam logic [3:0]  LIN_MAX        = 4'ha;
  localparam logic [5:0]  LIN_UNITY      = 6'h20;
  localparam int          LIN_SHIFT      = 5;
  localparam int          STAT_ABORT_BIT = 16;

  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_FIXED     = 2'h1;
  localparam logic [1:0]  MODE_SPEED     = 2'h2;

  // Word indices; byte address is four times the index
  localparam logic [3:0]  IDX_TYPE        = 4'h0;
  localparam logic [3:0]  IDX_LIN_RISE    = 4'h1;
  localparam logic [3:0]  IDX_LIN_FALL    = 4'h2;
  localparam logic [3:0]  IDX_T_RISE_ZERO = 4'h3;
  localparam logic [3:0]  IDX_T_FALL_ZERO = 4'h4;
  localparam logic [3:0]  IDX_T_RISE_HIGH = 4'h5;
  localparam logic [3:0]  IDX_T_FALL_HIGH = 4'h6;
  localparam logic [3:0]  IDX_SPEED_LIMIT = 4'h7;
  localparam logic [3:0]  IDX_FAST_THR    = 4'h8;
  localparam logic [3:0]  IDX_T_FAST      = 4'h9;
  localparam logic [3:0]  IDX_ABORT_THR   = 4'ha;
  localparam logic [3:0]  IDX_T_ABORT     = 4'hb;
  localparam logic [3:0]  IDX_STATUS      = 4'hc;

  localparam logic [15:0] CFG_RST [CFG_N] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h00c8, 16'h015e, 16'h00c8,
    16'h015e, 16'h01f4, 16'h03e8, 16'h0064, 16'h0000, 16'h0064};

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } srl_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } srl_wb_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_INTERP = 4'h2,
    ST_STEP   = 4'h4,
    ST_APPLY  = 4'h8
  } srl_state_t;

  typedef enum logic [3:0] {
    CAT_UP    = 4'h1,
    CAT_SLOW  = 4'h2,
    CAT_FAST  = 4'h4,
    CAT_ABORT = 4'h8
  } srl_cat_t;
endpackage

//--- src/srl_div.sv
// Restoring divider, 32 by 16 bits, one quotient bit per clock
`timescale 1ns/1ps
module srl_div (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [31:0] num,
  input  wire logic [15:0] den,
  output logic             done,
  output logic [31:0]      quo
);
  logic [16:0] rem_q;
  logic [31:0] quo_q;
  logic [15:0] den_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic        done_q;

  wire  [16:0] rem_sh = {rem_q[15:0], quo_q[31]};
  wire         fits   = rem_sh >= {1'b0, den_q};
  wire  [16:0] rem_nx = fits ? rem_sh - {1'b0, den_q} : rem_sh;
  wire         last   = cnt_q == 6'h1f;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rem_q  <= 17'h00000;
      quo_q  <= 32'h00000000;
      den_q  <= 16'h0000;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      rem_q  <= 17'h00000;
      quo_q  <= num;
      den_q  <= den;
      cnt_q  <= 6'h00;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      rem_q  <= rem_nx;
      quo_q  <= {quo_q[30:0], fits};
      cnt_q  <= cnt_q + 6'h01;
      busy_q <= !last;
      done_q <= last;
    end else begin
      done_q <= 1'b0;
    end
  end

  assign done = done_q;
  assign quo  = quo_q;
endmodule

//--- src/srl_limiter.sv
// Speed dependent anti-jerk flow ramp limiter with Wishbone registers
`timescale 1ns/1ps
module srl_limiter #(
  parameter int unsigned TICK_CYCLES = srl_pkg::TICK_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire srl_pkg::srl_wb_req_t wb_req,
  output srl_pkg::srl_wb_rsp_t      wb_rsp,
  input  wire logic signed [10:0]   flow_req,
  input  wire logic [9:0]           speed,
  output logic signed [10:0]        flow_limited,
  output logic                      abort_active
);
  logic [15:0]         cfg_q [srl_pkg::CFG_N];
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic [15:0]         tick_cnt_q;
  logic                tick_q;
  logic signed [10:0]  req_s1_q;
  logic signed [10:0]  req_s2_q;
  logic [9:0]          spd_s1_q;
  logic [9:0]          spd_s2_q;
  srl_pkg::srl_state_t state_q;
  srl_pkg::srl_state_t state_d;
  srl_pkg::srl_cat_t   cat_q;
  srl_pkg::srl_cat_t   cat_d;
  logic signed [27:0]  cur_q;
  logic signed [27:0]  cur_d;
  logic signed [27:0]  tgt_q;
  logic [15:0]         t_lo_q;
  logic                t_rise_q;
  logic [5:0]          fac_q;
  logic [26:0]         step_q;
  logic                abort_q;
  logic                abort_set_q;
  logic                div_done;
  logic [31:0]         div_quo;

  function automatic logic [15:0] tclamp(input logic [15:0] t);
    tclamp = (t < srl_pkg::TIME_MIN) ? srl_pkg::TIME_MIN :
             (t > srl_pkg::TIME_MAX) ? srl_pkg::TIME_MAX : t;
  endfunction

  function automatic logic [3:0] lclamp(input logic [15:0] l);
    lclamp = (l > 16'(srl_pkg::LIN_MAX)) ? srl_pkg::LIN_MAX : l[3:0];
  endfunction

  // Bus decode
  wire [3:0] wb_idx = wb_req.adr[5:2];
  wire       wb_map = (wb_req.adr[7:6] == 2'h0) && (wb_idx <= srl_pkg::IDX_STATUS);
  wire       wb_go  = wb_req.cyc && wb_req.stb && !ack_q;
  // Writes land on the ack edge, while the master still holds its request
  wire       wb_wr  = wb_req.cyc && wb_req.stb && wb_req.we && ack_q && wb_map;
  wire [31:0] status_word = {15'h0000, abort_q, 5'h00, cur_q[26:16]};
  wire [31:0] rd_word = !wb_map ? 32'h00000000 :
                        (wb_idx == srl_pkg::IDX_STATUS) ? status_word :
                        {16'h0000, cfg_q[wb_idx]};

  // Configuration words; tclamp keeps every time inside 1..1000 ms
  wire [1:0]  mode      = cfg_q[srl_pkg::IDX_TYPE][1:0];
  wire        ramp_on   = (mode == srl_pkg::MODE_FIXED) || (mode == srl_pkg::MODE_SPEED);
  wire [3:0]  lin_rise  = lclamp(cfg_q[srl_pkg::IDX_LIN_RISE]);
  wire [3:0]  lin_fall  = lclamp(cfg_q[srl_pkg::IDX_LIN_FALL]);
  wire [15:0] t_rise0   = tclamp(cfg_q[srl_pkg::IDX_T_RISE_ZERO]);
  wire [15:0] t_fall0   = tclamp(cfg_q[srl_pkg::IDX_T_FALL_ZERO]);
  wire [15:0] t_riseh   = tclamp(cfg_q[srl_pkg::IDX_T_RISE_HIGH]);
  wire [15:0] t_fallh   = tclamp(cfg_q[srl_pkg::IDX_T_FALL_HIGH]);
  wire [15:0] t_fast    = tclamp(cfg_q[srl_pkg::IDX_T_FAST]);
  wire [15:0] t_abort   = tclamp(cfg_q[srl_pkg::IDX_T_ABORT]);
  wire [15:0] spd_limit = cfg_q[srl_pkg::IDX_SPEED_LIMIT];
  wire [15:0] fast_thr  = cfg_q[srl_pkg::IDX_FAST_THR];
  wire [15:0] abort_thr = cfg_q[srl_pkg::IDX_ABORT_THR];

  // Request and present flow in sign and magnitude
  wire signed [10:0] req_c = (req_s2_q > $signed(srl_pkg::FLOW_MAX)) ?
                             $signed(srl_pkg::FLOW_MAX) :
                             (req_s2_q < -$signed(srl_pkg::FLOW_MAX)) ?
                             -$signed(srl_pkg::FLOW_MAX) : req_s2_q;
  wire        req_neg  = req_c[10];
  wire [10:0] req_mag  = req_neg ? 11'(-req_c) : req_c;
  wire        cur_neg  = cur_q[27];
  wire [27:0] cur_absf = cur_neg ? 28'(-cur_q) : cur_q;
  wire [10:0] cur_mag  = cur_absf[26:16];
  wire        opposite = (cur_q != 28'sh0) && (req_c != 11'sh0) && (cur_neg != req_neg);
  wire [10:0] tgt_mag  = opposite ? 11'h000 : req_mag;
  wire signed [27:0] req_fx = {req_c[10], req_c, 16'h0000};
  wire signed [27:0] tgt_fx = opposite ? 28'sh0 : req_fx;
  wire        rising   = {tgt_mag, 16'h0000} > cur_absf[26:0];

  // Reverse request strong enough aborts the slow fall
  wire abort_hit = opposite && (abort_thr != srl_pkg::THR_OFF) &&
                   (16'(req_mag) > abort_thr) &&
                   (16'(cur_mag) <= fast_thr);
  wire in_fast   = 16'(cur_mag) > fast_thr;

  always_comb begin
    if (rising) begin
      cat_d = srl_pkg::CAT_UP;
    end else if (abort_q || abort_hit) begin
      cat_d = srl_pkg::CAT_ABORT;
    end else if (in_fast) begin
      cat_d = srl_pkg::CAT_FAST;
    end else begin
      cat_d = srl_pkg::CAT_SLOW;
    end
  end

  // Time pair of the category; fast and abort have no speed pair
  wire [15:0] t_lo = (cat_d == srl_pkg::CAT_UP)   ? t_rise0 :
                     (cat_d == srl_pkg::CAT_SLOW) ? t_fall0 :
                     (cat_d == srl_pkg::CAT_FAST) ? t_fast  : t_abort;
  wire [15:0] t_hi = (cat_d == srl_pkg::CAT_UP)   ? t_riseh :
                     (cat_d == srl_pkg::CAT_SLOW) ? t_fallh : t_lo;
  wire        at_limit   = (spd_limit == 16'h0000) || ({6'h00, spd_s2_q} >= spd_limit);
  wire        speed_mode = mode == srl_pkg::MODE_SPEED;
  wire [15:0] t_direct   = (speed_mode && at_limit) ? t_hi : t_lo;
  wire        need_interp = speed_mode && !at_limit && (t_lo != t_hi);
  wire [15:0] t_span  = (t_hi >= t_lo) ? t_hi - t_lo : t_lo - t_hi;
  wire [31:0] i_num   = 32'(t_span) * 32'(spd_s2_q);

  // Progressive shaping: slower steps near closed spool
  wire [1:0]  zone_w = (cur_mag < srl_pkg::BP_LOW)  ? 2'h3 :
                       (cur_mag < srl_pkg::BP_MID)  ? 2'h2 :
                       (cur_mag < srl_pkg::BP_HIGH) ? 2'h1 : 2'h0;
  wire [3:0]  lin_sel = (cat_d == srl_pkg::CAT_UP)   ? lin_rise :
                        (cat_d == srl_pkg::CAT_SLOW) ? lin_fall : 4'h0;
  wire [5:0]  fac_d   = srl_pkg::LIN_UNITY - (6'(lin_sel) * 6'(zone_w));

  wire        tick_go   = (state_q == srl_pkg::ST_IDLE) && tick_q;
  wire [15:0] t_interp  = t_rise_q ? t_lo_q + div_quo[15:0] : t_lo_q - div_quo[15:0];
  wire        div_start = (tick_go && ramp_on) ||
                          ((state_q == srl_pkg::ST_INTERP) && div_done);
  wire [31:0] div_num   = (tick_go && need_interp) ? i_num : srl_pkg::FULL_SCALE_FX;
  wire [15:0] div_den   = (state_q == srl_pkg::ST_INTERP) ? t_interp :
                          need_interp ? spd_limit : t_direct;
  wire [31:0] step_full = div_quo * {26'h0000000, fac_q};

  // Move toward the target by one step without passing it
  wire signed [28:0] diff    = {tgt_q[27], tgt_q} - {cur_q[27], cur_q};
  wire [28:0]        diff_m  = diff[28] ? 29'(-diff) : diff;
  wire               reach   = diff_m <= {2'h0, step_q};
  wire signed [27:0] cur_nx  = reach ? tgt_q :
                               diff[28] ? cur_q - {1'b0, step_q} : cur_q + {1'b0, step_q};
  wire               abort_d = abort_set_q ||
                               (abort_q && (cur_nx != 28'sh0) && (cat_q != srl_pkg::CAT_UP));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      srl_pkg::ST_IDLE:   if (tick_q && ramp_on) begin
        state_d = need_interp ? srl_pkg::ST_INTERP : srl_pkg::ST_STEP;
      end
      srl_pkg::ST_INTERP: if (div_done) begin
        state_d = srl_pkg::ST_STEP;
      end
      srl_pkg::ST_STEP:   if (div_done) begin
        state_d = srl_pkg::ST_APPLY;
      end
      srl_pkg::ST_APPLY:  state_d = srl_pkg::ST_IDLE;
    endcase
  end

  // Disabled or unknown type passes the request straight through
  assign cur_d = (tick_go && !ramp_on) ? req_fx :
                 (state_q == srl_pkg::ST_APPLY) ? cur_nx : cur_q;

  srl_div u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .done    (div_done),
    .quo     (div_quo)
  );

  for (genvar i = 0; i < srl_pkg::CFG_N; i++) begin : g_cfg
    wire wr_hit = wb_wr && (wb_idx == 4'(i));
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        cfg_q[i] <= srl_pkg::CFG_RST[i];
      end else if (wr_hit) begin
        cfg_q[i] <= {wb_req.sel[1] ? wb_req.dat[15:8] : cfg_q[i][15:8],
                     wb_req.sel[0] ? wb_req.dat[7:0]  : cfg_q[i][7:0]};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= wb_go;
      rdat_q <= wb_go ? rd_word : 32'h00000000;
    end
  end

  // Request and speed come from another clock; two stages before use
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      req_s1_q <= 11'sh000;
      req_s2_q <= 11'sh000;
      spd_s1_q <= 10'h000;
      spd_s2_q <= 10'h000;
    end else begin
      req_s1_q <= flow_req;
      req_s2_q <= req_s1_q;
      spd_s1_q <= speed;
      spd_s2_q <= spd_s1_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= tick_cnt_q == 16'(TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q     <= srl_pkg::ST_IDLE;
      cat_q       <= srl_pkg::CAT_UP;
      cur_q       <= 28'sh0;
      abort_q     <= 1'b0;
      abort_set_q <= 1'b0;
      tgt_q       <= 28'sh0;
      t_lo_q      <= srl_pkg::TIME_MIN;
      t_rise_q    <= 1'b0;
      fac_q       <= srl_pkg::LIN_UNITY;
      step_q      <= 27'h0000000;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      if (tick_go) begin
        cat_q       <= cat_d;
        tgt_q       <= tgt_fx;
        t_lo_q      <= t_lo;
        t_rise_q    <= t_hi >= t_lo;
        fac_q       <= fac_d;
        abort_set_q <= ramp_on && !rising && abort_hit;
      end
      if (state_q == srl_pkg::ST_STEP && div_done) begin
        step_q <= step_full[31:srl_pkg::LIN_SHIFT];
      end
      if (tick_go && !ramp_on) begin
        abort_q <= 1'b0;
      end else if (state_q == srl_pkg::ST_APPLY) begin
        abort_q <= abort_d;
      end
    end
  end

  assign wb_rsp       = '{ack: ack_q, dat: rdat_q};
  assign flow_limited = cur_q[26:16];
  assign abort_active = abort_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_ramp_tick;
    tick_go && ramp_on;
  endsequence
  sequence s_applied;
    ##[1:80] (state_q == srl_pkg::ST_APPLY);
  endsequence

  tick_done_a: assert property (s_ramp_tick |-> s_applied)
    else $error("ramp tick did not reach apply in time");
  step_bound_a: assert property ((state_q == srl_pkg::ST_APPLY) |=>
      (((cur_q - $past(cur_q)) <= $signed({1'b0, $past(step_q)})) &&
       ((($past(cur_q) - cur_q)) <= $signed({1'b0, $past(step_q)}))))
    else $error("limited flow moved more than one step");
  no_overshoot_a: assert property ((state_q == srl_pkg::ST_APPLY) |=>
      (($past(tgt_q) >= $past(cur_q)) ? (cur_q <= $past(tgt_q) && cur_q >= $past(cur_q))
                                      : (cur_q >= $past(tgt_q) && cur_q <= $past(cur_q))))
    else $error("limited flow passed the target");
  reset_zero_a: assert property ($fell(reset) |-> cur_q == 28'sh0 && !abort_q)
    else $error("state not cleared by reset");
  pass_through_a: assert property ((tick_go && !ramp_on) |=> cur_q == $past(req_fx))
    else $error("disabled ramp did not pass the request");
  abort_off_a: assert property ((abort_thr == srl_pkg::THR_OFF) |-> !abort_hit)
    else $error("abort armed while disabled");
  abort_any_a: assert property ((tick_go && ramp_on && !rising && opposite &&
      abort_thr == 16'h0000 && !in_fast) |=> abort_set_q ##[1:80] abort_q)
    else $error("slight reverse request did not abort");
  abort_use_a: assert property ((tick_go && ramp_on && abort_q && !rising) |=>
      cat_q == srl_pkg::CAT_ABORT)
    else $error("aborted fall not using abort time");
  fast_off_a: assert property ((tick_go && fast_thr == srl_pkg::THR_OFF) |=>
      cat_q != srl_pkg::CAT_FAST)
    else $error("fast fall used while disabled");
  high_speed_a: assert property ((tick_go && speed_mode && at_limit && rising) |->
      !need_interp && div_den == t_riseh)
    else $error("high speed rise time not used");
  interp_range_a: assert property ((state_q == srl_pkg::ST_INTERP && div_done) |->
      (t_rise_q ? (t_interp >= t_lo_q) : (t_interp <= t_lo_q)) && t_interp >= srl_pkg::TIME_MIN)
    else $error("interpolated time out of range");
  zone_low_a: assert property ((tick_go && cur_mag < srl_pkg::BP_LOW && rising) |=>
      fac_q == srl_pkg::LIN_UNITY - (6'($past(lin_rise)) * 6'h03))
    else $error("low zone shaping factor wrong");
  ack_pulse_a: assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");
endmodule

//--- verification/srl_flow_src.sv
// Model of the steering device flow request and vehicle speed source
`timescale 1ns/1ps
module srl_flow_src (
  input  wire logic          clk_sys,
  output logic signed [10:0] flow_req,
  output logic [9:0]         speed
);
  initial begin
    flow_req = '0;
    speed    = '0;
  end

  // Levels change just after an edge and hold until the next call
  task automatic put(input logic signed [10:0] f, input logic [9:0] s);
    @(posedge clk_sys);
    flow_req <= f;
    speed    <= s;
  endtask
endmodule

//--- verification/tb.sv
// Self-checking bench of the speed dependent flow ramp limiter
`timescale 1ns/1ps
module tb;
  // Short tick keeps the run small; every expectation is per tick
  localparam int unsigned TICKS = 200;

  logic                 clk_sys;
  logic                 reset;
  srl_pkg::srl_wb_req_t wb_req;
  srl_pkg::srl_wb_rsp_t wb_rsp;
  logic signed [10:0]   flow_req;
  logic [9:0]           speed;
  logic signed [10:0]   flow_limited;
  logic                 abort_active;
  logic [31:0]          rd;
  int                   error_cnt;
  int                   cmp_count;

  srl_limiter #(.TICK_CYCLES(TICKS)) i_srl_limiter (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .wb_req       (wb_req),
    .wb_rsp       (wb_rsp),
    .flow_req     (flow_req),
    .speed        (speed),
    .flow_limited (flow_limited),
    .abort_active (abort_active)
  );

  srl_flow_src i_srl_flow_src (
    .clk_sys  (clk_sys),
    .flow_req (flow_req),
    .speed    (speed)
  );

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Classic single cycle; the slave answers in its own time
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  // Waits for the next ramp update, at most two ticks plus 50 cycles, then judges it
  task automatic nxt(input int exp, input logic ab);
    logic signed [10:0] prev;
    prev = flow_limited;
    repeat (2 * TICKS + 50) begin
      @(negedge clk_sys);
      if (flow_limited !== prev) break;
    end
    check(flow_limited, exp);
    check(abort_active, ab);
  endtask

  task automatic t_defaults();
    logic [15:0] exp [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h00c8, 16'h015e, 16'h00c8,
                              16'h015e, 16'h01f4, 16'h03e8, 16'h0064, 16'h0000, 16'h0064};
    check(flow_limited, 32'h0);
    check(abort_active, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      check(rd, {16'h0000, exp[i]});
    end
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_rise();
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h0c, 32'ha);
    wb(1'b1, 8'h14, 32'ha);
    wb(1'b1, 8'h10, 32'ha);
    wb(1'b1, 8'h18, 32'ha);
    i_srl_flow_src.put(11'sd1000, 10'd0);
    for (int k = 1; k <= 10; k++) nxt(100 * k, 1'b0);
    repeat (3 * TICKS) @(negedge clk_sys);
    check(flow_limited, 32'd1000);
  endtask

  task automatic t_fast();
    wb(1'b1, 8'h20, 32'h1f4);
    wb(1'b1, 8'h24, 32'h2);
    i_srl_flow_src.put(11'sd0, 10'd0);
    nxt(500, 1'b0);
    nxt(400, 1'b0);
    for (int v = 300; v >= 0; v -= 100) nxt(v, 1'b0);
    wb(1'b1, 8'h20, 32'h3e8);
  endtask

  task automatic t_speed();
    wb(1'b1, 8'h14, 32'h14);
    wb(1'b1, 8'h1c, 32'h64);
    i_srl_flow_src.put(11'sd1000, 10'd1000);
    nxt(50, 1'b0);
    nxt(100, 1'b0);
    i_srl_flow_src.put(11'sd0, 10'd1000);
    nxt(0, 1'b0);
    i_srl_flow_src.put(11'sd1000, 10'd50);
    nxt(66, 1'b0);
    nxt(133, 1'b0);
    nxt(199, 1'b0);
    i_srl_flow_src.put(11'sd0, 10'd50);
    nxt(99, 1'b0);
    nxt(0, 1'b0);
  endtask

  task automatic t_shape();
    int exp [9] = '{6, 12, 18, 25, 31, 37, 43, 50, 87};
    wb(1'b1, 8'h04, 32'ha);
    i_srl_flow_src.put(11'sd1000, 10'd0);
    foreach (exp[i]) nxt(exp[i], 1'b0);
    wb(1'b1, 8'h04, 32'h0);
    repeat (15 * TICKS) @(negedge clk_sys);
    check(flow_limited, 32'd1000);
  endtask

  task automatic t_abort();
    wb(1'b1, 8'h28, 32'h3e8);
    wb(1'b1, 8'h2c, 32'h5);
    i_srl_flow_src.put(-11'sd1000, 10'd0);
    nxt(900, 1'b0);
    wb(1'b1, 8'h28, 32'h1f4);
    i_srl_flow_src.put(-11'sd400, 10'd0);
    nxt(800, 1'b0);
    i_srl_flow_src.put(-11'sd600, 10'd0);
    nxt(600, 1'b1);
    nxt(400, 1'b1);
    wb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h00010190);
    i_srl_flow_src.put(11'sd1000, 10'd0);
    nxt(500, 1'b0);
    wb(1'b1, 8'h28, 32'h0);
    i_srl_flow_src.put(-11'sd1, 10'd0);
    nxt(300, 1'b1);
  endtask

  task automatic t_mid_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    @(negedge clk_sys);
    check(flow_limited, 32'h0);
    check(abort_active, 32'h0);
    @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h000000c8);
    nxt(-1, 1'b0);
  endtask

  initial begin
    reset     = 1'b1;
    wb_req    = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    t_defaults();
    t_rise();
    t_fast();
    t_speed();
    t_shape();
    t_abort();
    t_mid_reset();
    close_out();
  end

  // Whole sequence needs about 12000 cycles; five times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end
endmodule
